/* hdl/ddrsw_pkg.sv */
// package: constants, types and helpers of the two-word burst sram write path
package ddrsw_pkg;

  // array geometry
  localparam int DATA_W = 18;             // one data word on the pins
  localparam int BYTE_W = 9;              // one byte lane incl. parity bit
  localparam int NBYTES = 2;              // byte lanes per word
  localparam int ADDR_W_DEF = 21;         // word address width
  localparam int ROW_W = 2 * DATA_W;      // one burst row of two words
  localparam int ROW_BYTES = 2 * NBYTES;  // byte lanes per row

  // timing figures
  localparam int CLK_SYS_NS = 5;          // system clock period in ns
  localparam int DLL_STOP_NS = 30;        // least clock stop that resets the dll
  localparam int DLL_LOCK_CYC = 1024;     // input clock cycles to dll lock
  localparam int IMP_PERIOD_CYC = 1024;   // cycles between impedance updates

  // reset values
  localparam logic [DATA_W-1:0] DQ_RST = 18'h00000;

  // command decoded from the load and read/write selects
  typedef enum {CMD_NOP, CMD_READ, CMD_WRITE} ddrsw_cmd_type;

  // one captured data word with its byte enables (active high)
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [NBYTES-1:0] be;
  } ddrsw_word_type;

  // one burst row with its byte enables
  typedef struct packed {
    logic [ROW_W-1:0] data;
    logic [ROW_BYTES-1:0] be;
  } ddrsw_row_type;

  // decode the command pins of one input clock rise
  function automatic ddrsw_cmd_type ddrsw_decode(input logic load_n, input logic rw);
    ddrsw_cmd_type c;
    c = CMD_NOP;
    if (!load_n) begin
      c = rw ? CMD_READ : CMD_WRITE;
    end
    return c;
  endfunction

  // place the two burst words in the row by the first address lsb
  function automatic ddrsw_row_type ddrsw_pack_row(input ddrsw_word_type first,
                                                   input ddrsw_word_type second,
                                                   input logic lsb);
    ddrsw_row_type r;
    r = '0;
    if (lsb) begin
      r.data = {first.data, second.data};
      r.be = {first.be, second.be};
    end else begin
      r.data = {second.data, first.data};
      r.be = {second.be, first.be};
    end
    return r;
  endfunction

endpackage

/* hdl/ddrsw_array.sv */
// storage array of burst rows with a byte-masked write port and a flow-through read
`timescale 1ns/1ps
`default_nettype none
module ddrsw_array
  import ddrsw_pkg::*;
#(
  parameter int ROW_AW = ADDR_W_DEF - 1
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [ROW_AW-1:0] waddr,
  input wire ddrsw_row_type wrow,
  // read port
  input wire logic [ROW_AW-1:0] raddr,
  output logic [ROW_W-1:0] rdata
);

  // row storage, indexed by row address
  logic [ROW_W-1:0] mem [0:(1<<ROW_AW)-1];

  // byte-masked write; lanes without enable keep their contents
  always_ff @(posedge clk) begin
    for (int i = 0; i < ROW_BYTES; i++) begin
      if (we && wrow.be[i]) begin
        mem[waddr][i*BYTE_W +: BYTE_W] <= wrow.data[i*BYTE_W +: BYTE_W];
      end
    end
  end

  // flow-through read
  assign rdata = mem[raddr];

endmodule
`default_nettype wire

/* hdl/ddrsw_top.sv */
// device-side logic of a two-word burst ddr sram: write path, reads, echo, dll, impedance
//
// How it works
// - write starts on load and rw low
// - second burst address inverts the lsb
// - first word latched at next k rise
// - second word at k-bar rise, row posted to holding at next k rise
// - deselect finishes pending writes, ignores inputs
// - select 0 gates low byte, 1 high
// - both selects high writes nothing
// - single clock: k pair drives outputs
// - reads keep last write posted in holding
// - read of fresh write bypasses the array
// - impedance update every 1024 cycles
// - free-running echo clocks from the k pair
// - dll locks 1024 cycles after stable clock
// - stopped clock for 30 ns resets dll
// - dll off pin low disables dll
// - write data at t+1 k and k-bar
// - read data at t+1 k-bar, t+2 k
// - nop leaves data pins high impedance
// - power up deselected, outputs high impedance
// - after last read, tri-state following k rise
`timescale 1ns/1ps
`default_nettype none
module ddrsw_top
  import ddrsw_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LOCK_CYC = DLL_LOCK_CYC,
  parameter int IMP_CYC = IMP_PERIOD_CYC,
  parameter int STOP_NS = DLL_STOP_NS
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // input clock k (k-bar rise is its falling edge)
  input wire logic clk_link,
  // command pins
  input wire logic load_select_n,
  input wire logic rw_select,
  input wire logic [ADDR_W-1:0] addr,
  // data pins
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [NBYTES-1:0] byte_write_select_n,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  // output clock pair, used as strap
  input wire logic out_clk_p,
  input wire logic out_clk_n,
  // dll control
  input wire logic dll_off_n,
  // echo clocks and status
  output logic echo_clock,
  output logic echo_clock_n,
  output logic single_clock_mode,
  output logic dll_locked,
  output logic impedance_update
);

  // least stop time rounds up to whole system cycles
  localparam int STOP_CYC = (STOP_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam int STOP_W = $clog2(STOP_CYC + 1);
  localparam logic [STOP_W-1:0] STOP_LIM = STOP_W'(STOP_CYC);
  localparam int LOCK_W = $clog2(LOCK_CYC + 1);
  localparam logic [LOCK_W-1:0] LOCK_LIM = LOCK_W'(LOCK_CYC - 1);
  localparam int IMP_W = $clog2(IMP_CYC + 1);
  localparam logic [IMP_W-1:0] IMP_LIM = IMP_W'(IMP_CYC - 1);

  // link-domain reset, brought over from the system reset
  logic link_rst_meta_q, link_rst_n_q;
  // clock stop watch: beat_q toggles on every k rise and is watched from the system side
  logic beat_q, beat_meta_q, beat_sync_q, beat_seen_q;
  logic [STOP_W-1:0] idle_cnt_q; // system cycles without a k rise
  logic stop_req_q, req_meta_q, req_sync_q; // dll reset request and its link copies
  logic ack_q, ack_meta_q, ack_sync_q; // link acknowledge and its system copies
  // dll, strap, impedance and echo state
  logic [LOCK_W-1:0] lock_cnt_q; // k rises since the dll restarted
  logic lock_done_q, off_meta_q, off_sync_q, dll_locked_q;
  logic [1:0] strap_meta_q, strap_sync_q; // output clock pair as seen at k rises
  logic strap_taken_q, single_clock_q;
  logic [IMP_W-1:0] imp_cnt_q; // k rises since the last impedance update
  logic imp_update_q, echo_p_q, echo_n_q;
  // write path
  ddrsw_cmd_type cmd_now; // command at this k rise
  logic wr_cyc_q, burst_busy_q; // write taken last rise; second word due at k-bar
  logic [ADDR_W-1:0] wr_addr_q, burst_addr_q;
  ddrsw_word_type first_q, second_q; // second is written on the k-bar rise
  ddrsw_row_type hold_q; // posted write data
  logic [ADDR_W-2:0] hold_row_q;
  logic hold_valid_q, commit; // posted row pending; array write at this rise
  // read path
  logic rd_cyc_q, rd_fetch_q, hold_hit;
  logic [ADDR_W-1:0] rd_addr_q, fetch_addr_q;
  logic [ROW_W-1:0] arr_rdata, merged_row;
  logic [DATA_W-1:0] word_a1, word_a2, stage_q;
  logic [DATA_W-1:0] neg_q, pos_q; // words shown in the k low and k high phase
  logic neg_oe_q, pos_oe_q;

  // system domain: bring the link heartbeat over and look for a stall
  always_ff @(posedge clk_sys) begin
    beat_meta_q <= beat_q;
    beat_sync_q <= beat_meta_q;
    if (!reset_n) begin
      beat_seen_q <= 1'b0;
    end else begin
      beat_seen_q <= beat_sync_q;
    end
  end

  // count system cycles without a k rise, saturating at the limit
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      idle_cnt_q <= '0;
    end else if (beat_sync_q != beat_seen_q) begin
      idle_cnt_q <= '0;
    end else if (idle_cnt_q != STOP_LIM) begin
      idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  // four-phase request to reset the dll, held until the link acknowledges
  always_ff @(posedge clk_sys) begin
    ack_meta_q <= ack_q;
    ack_sync_q <= ack_meta_q;
    if (!reset_n) begin
      stop_req_q <= 1'b0;
    end else if (!stop_req_q && !ack_sync_q && idle_cnt_q == STOP_LIM) begin
      stop_req_q <= 1'b1;       // clock stopped or too slow
    end else if (stop_req_q && ack_sync_q) begin
      stop_req_q <= 1'b0;
    end
  end

  // link domain housekeeping: reset synchroniser
  always_ff @(posedge clk_link) begin
    link_rst_meta_q <= reset_n;
    link_rst_n_q <= link_rst_meta_q;
  end

  // heartbeat and acknowledge of the dll reset request
  always_ff @(posedge clk_link) begin
    req_meta_q <= stop_req_q;
    req_sync_q <= req_meta_q;
    if (!link_rst_n_q) begin
      beat_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      beat_q <= ~beat_q;
      ack_q <= req_sync_q;
    end
  end

  // dll lock counter, restarted by reset or a clock stop
  always_ff @(posedge clk_link) begin
    if (!link_rst_n_q || req_sync_q) begin
      lock_cnt_q <= '0;         // relock after clock returns
      lock_done_q <= 1'b0;
    end else if (lock_cnt_q == LOCK_LIM) begin
      lock_done_q <= 1'b1;      // locked after stable clock
    end else begin
      lock_cnt_q <= lock_cnt_q + 1'b1;
    end
  end

  // dll enable pin and lock status
  always_ff @(posedge clk_link) begin
    off_meta_q <= dll_off_n;
    off_sync_q <= off_meta_q;
    if (!link_rst_n_q) begin
      dll_locked_q <= 1'b0;
    end else begin
      dll_locked_q <= lock_done_q & off_sync_q;  // pin low disables dll
    end
  end

  // output clock strap, caught once after reset release
  always_ff @(posedge clk_link) begin
    strap_meta_q <= {out_clk_p, out_clk_n};
    strap_sync_q <= strap_meta_q;
    if (!link_rst_n_q) begin
      strap_taken_q <= 1'b0;
      single_clock_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      single_clock_q <= &strap_sync_q;  // pair held high
    end
  end

  // periodic output impedance update
  always_ff @(posedge clk_link) begin
    if (!link_rst_n_q) begin
      imp_cnt_q <= '0;
      imp_update_q <= 1'b0;
    end else if (imp_cnt_q == IMP_LIM) begin
      imp_cnt_q <= '0;
      imp_update_q <= 1'b1;     // one pulse per period
    end else begin
      imp_cnt_q <= imp_cnt_q + 1'b1;
      imp_update_q <= 1'b0;
    end
  end

  // echo clocks: each edge of the k pair flips one echo output
  always_ff @(posedge clk_link) begin
    if (!link_rst_n_q) begin
      echo_p_q <= 1'b0;
    end else begin
      echo_p_q <= ~echo_p_q;    // free running from k
    end
  end

  always_ff @(negedge clk_link) begin
    if (!link_rst_n_q) begin
      echo_n_q <= 1'b0;
    end else begin
      echo_n_q <= ~echo_n_q;    // free running from k-bar
    end
  end

  // link write path: command of this rise; nop cycles take no new command but still finish pending writes
  assign cmd_now = ddrsw_decode(load_select_n, rw_select);

  // take the write command and its address
  always_ff @(posedge clk_link) begin
    if (!link_rst_n_q) begin
      wr_cyc_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_cyc_q <= (cmd_now == CMD_WRITE);
      if (cmd_now == CMD_WRITE) begin
        wr_addr_q <= addr;
      end
    end
  end

  // first word and its selects at the k rise after the command
  always_ff @(posedge clk_link) begin
    if (!link_rst_n_q) begin
      burst_busy_q <= 1'b0;
      burst_addr_q <= '0;
      first_q <= '0;
    end else begin
      burst_busy_q <= wr_cyc_q;
      if (wr_cyc_q) begin
        burst_addr_q <= wr_addr_q;
        first_q <= '{data: dq_in, be: ~byte_write_select_n};
      end
    end
  end

  // second word with its own selects at the following k-bar rise
  always_ff @(negedge clk_link) begin
    if (!link_rst_n_q) begin
      second_q <= '0;
    end else if (burst_busy_q) begin
      second_q <= '{data: dq_in, be: ~byte_write_select_n};
    end
  end

  // the held row reaches the array unless a read occupies the cycle and no burst completes at this rise
  assign commit = hold_valid_q && (burst_busy_q || cmd_now != CMD_READ);

  // completed burst moves into the holding registers
  always_ff @(posedge clk_link) begin
    if (!link_rst_n_q) begin
      hold_valid_q <= 1'b0;
      hold_row_q <= '0;
      hold_q <= '0;
    end else if (burst_busy_q) begin
      hold_valid_q <= 1'b1;
      hold_row_q <= burst_addr_q[ADDR_W-1:1];
      hold_q <= ddrsw_pack_row(first_q, second_q, burst_addr_q[0]);
    end else if (commit) begin
      hold_valid_q <= 1'b0;
    end
  end

  // storage; lanes with no select stay unaltered
  ddrsw_array #(
    .ROW_AW(ADDR_W - 1)
  ) ddrsw_array_i (
    .clk(clk_link),
    .we(commit),
    .waddr(hold_row_q),
    .wrow(hold_q),
    .raddr(fetch_addr_q[ADDR_W-1:1]),
    .rdata(arr_rdata)
  );

  // link read path: take the read command, then advance to the fetch stage
  always_ff @(posedge clk_link) begin
    if (!link_rst_n_q) begin
      rd_cyc_q <= 1'b0;
      rd_addr_q <= '0;
      rd_fetch_q <= 1'b0;
      fetch_addr_q <= '0;
    end else begin
      rd_cyc_q <= (cmd_now == CMD_READ);
      if (cmd_now == CMD_READ) begin
        rd_addr_q <= addr;
      end
      rd_fetch_q <= rd_cyc_q;
      fetch_addr_q <= rd_addr_q;
    end
  end

  // merge the posted row over the array row on an address match
  assign hold_hit = hold_valid_q && (hold_row_q == fetch_addr_q[ADDR_W-1:1]);

  always_comb begin
    merged_row = arr_rdata;
    for (int i = 0; i < ROW_BYTES; i++) begin
      if (hold_hit && hold_q.be[i]) begin
        merged_row[i*BYTE_W +: BYTE_W] = hold_q.data[i*BYTE_W +: BYTE_W];
      end
    end
  end

  // first word at the read address, second at the lsb inverted
  assign word_a1 = fetch_addr_q[0] ? merged_row[ROW_W-1:DATA_W] : merged_row[DATA_W-1:0];
  assign word_a2 = fetch_addr_q[0] ? merged_row[DATA_W-1:0] : merged_row[ROW_W-1:DATA_W];

  // k-bar rise of t+1: first word out, second staged
  always_ff @(negedge clk_link) begin
    if (!link_rst_n_q) begin
      neg_q <= DQ_RST;
      stage_q <= DQ_RST;
      neg_oe_q <= 1'b0;         // deselected at power up
    end else begin
      neg_oe_q <= rd_fetch_q;   // no read: high impedance
      if (rd_fetch_q) begin
        neg_q <= word_a1;
        stage_q <= word_a2;
      end
    end
  end

  // k rise of t+2: second word out
  always_ff @(posedge clk_link) begin
    if (!link_rst_n_q) begin
      pos_q <= DQ_RST;
      pos_oe_q <= 1'b0;
    end else begin
      pos_oe_q <= neg_oe_q;     // last word then release
      if (neg_oe_q) begin
        pos_q <= stage_q;
      end
    end
  end

  // ddr output stage: the k pair is also the output clock pair
  assign dq_out = clk_link ? pos_q : neg_q;
  assign dq_oe = clk_link ? pos_oe_q : neg_oe_q;

  // status and clock outputs
  assign echo_clock = echo_p_q;
  assign echo_clock_n = echo_n_q;
  assign single_clock_mode = single_clock_q;
  assign dll_locked = dll_locked_q;
  assign impedance_update = imp_update_q;

endmodule
`default_nettype wire

/* dv/ddrsw_top_props.sv */
// concurrent checks on the ports of the burst sram top
`timescale 1ns/1ps
`default_nettype none
module ddrsw_top_props
  import ddrsw_pkg::*;
#(
  parameter int LOCK_CYC = DLL_LOCK_CYC,
  parameter int IMP_CYC = IMP_PERIOD_CYC
) (
  // clock and reset
  input wire logic clk_link,
  input wire logic reset_n,
  // command and strap pins
  input wire logic load_select_n,
  input wire logic rw_select,
  input wire logic out_clk_p,
  input wire logic out_clk_n,
  input wire logic dll_off_n,
  // outputs watched
  input wire logic dq_oe,
  input wire logic echo_clock,
  input wire logic echo_clock_n,
  input wire logic single_clock_mode,
  input wire logic dll_locked,
  input wire logic impedance_update
);
  logic [2:0] rd_h_q; // read commands of the last three k rises
  logic [3:0] up_q; // k rises since reset release, saturating
  logic [15:0] imp_cnt_q; // k rises since the last impedance pulse
  logic imp_seen_q; // a first pulse has been seen
  logic [15:0] run_q; // k rises since reset, saturating at lock count
  // history of read commands, so output enable can be tied to them
  always_ff @(posedge clk_link) begin
    if (!reset_n) begin
      rd_h_q <= '0;
    end else begin
      rd_h_q <= {rd_h_q[1:0], !load_select_n && rw_select};
    end
  end
  // settle counter, lets the link reset synchroniser finish
  always_ff @(posedge clk_link) begin
    if (!reset_n) begin
      up_q <= '0;
    end else if (up_q != 4'h8) begin
      up_q <= up_q + 4'h1;
    end
  end
  // distance between impedance pulses
  always_ff @(posedge clk_link) begin
    if (!reset_n) begin
      imp_cnt_q <= '0;
      imp_seen_q <= 1'b0;
    end else if (impedance_update) begin
      imp_cnt_q <= 16'h0001;
      imp_seen_q <= 1'b1;
    end else begin
      imp_cnt_q <= imp_cnt_q + 16'h0001;
    end
  end
  // running time of the input clock since reset
  always_ff @(posedge clk_link) begin
    if (!reset_n) begin
      run_q <= '0;
    end else if (run_q < LOCK_CYC) begin
      run_q <= run_q + 16'h0001;
    end
  end
  a_oe_first_word: assert property (@(posedge clk_link) disable iff (!reset_n)
    dq_oe == rd_h_q[1]) else $error("enable in low phase not set by a read");
  a_oe_second_word: assert property (@(negedge clk_link) disable iff (!reset_n)
    dq_oe == rd_h_q[2]) else $error("enable in high phase not set by a read");
  a_echo_toggle: assert property (@(posedge clk_link) disable iff (!reset_n)
    up_q == 4'h8 |-> echo_clock != $past(echo_clock)) else $error("echo clock stuck");
  a_echo_n_toggle: assert property (@(negedge clk_link) disable iff (!reset_n)
    up_q == 4'h8 |-> echo_clock_n != $past(echo_clock_n)) else $error("echo clock n stuck");
  a_imp_period: assert property (@(posedge clk_link) disable iff (!reset_n)
    imp_seen_q && impedance_update |-> imp_cnt_q == IMP_CYC) else $error("impedance period");
  a_imp_gap: assert property (@(posedge clk_link) disable iff (!reset_n)
    imp_seen_q && !impedance_update |-> imp_cnt_q < IMP_CYC) else $error("impedance pulse late");
  a_dll_off: assert property (@(posedge clk_link) disable iff (!reset_n)
    !dll_off_n [*5] |-> !dll_locked) else $error("locked with dll off");
  a_lock_count: assert property (@(posedge clk_link) disable iff (!reset_n)
    dll_locked |-> run_q >= LOCK_CYC) else $error("lock too early");
  a_strap_held: assert property (@(posedge clk_link) disable iff (!reset_n)
    up_q == 4'h8 |-> $stable(single_clock_mode) && single_clock_mode == (out_clk_p && out_clk_n))
    else $error("strap result wrong");
endmodule
bind ddrsw_top ddrsw_top_props #(.LOCK_CYC(LOCK_CYC), .IMP_CYC(IMP_CYC)) ddrsw_top_props_i (
  .clk_link(clk_link), .reset_n(reset_n), .load_select_n(load_select_n),
  .rw_select(rw_select), .out_clk_p(out_clk_p), .out_clk_n(out_clk_n), .dll_off_n(dll_off_n),
  .dq_oe(dq_oe), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n),
  .single_clock_mode(single_clock_mode), .dll_locked(dll_locked),
  .impedance_update(impedance_update));
`default_nettype wire

/* dv/ddrsw_ctrl_model.sv */
// memory controller model driving command and write data pins one k cycle per call
`timescale 1ns/1ps
`default_nettype none
module ddrsw_ctrl_model
  import ddrsw_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  // link clock and device outputs
  input wire logic clk_link,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  // command and write data pins
  output logic load_select_n,
  output logic rw_select,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq_in,
  output logic [NBYTES-1:0] byte_write_select_n,
  // {enable, data} seen in high and low phase of the last cycle
  output logic [DATA_W:0] hi_s,
  output logic [DATA_W:0] lo_s
);
  ddrsw_word_type p1_q, p2_q, w2_q; // words of pending writes
  logic pv_q, w2v_q; // pending words are valid
  initial begin
    load_select_n = 1'b1;
    rw_select = 1'b0;
    addr = '0;
    dq_in = '0;
    byte_write_select_n = 2'h3;
    hi_s = '0;
    lo_s = '0;
    pv_q = 1'b0;
    w2v_q = 1'b0;
  end
  // op 0 nop, 1 write, 2 read; data goes out on the next cycle's k and k-bar rises
  task automatic cycle(input int op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d1,
                       input logic [NBYTES-1:0] s1, input logic [DATA_W-1:0] d2,
                       input logic [NBYTES-1:0] s2);
    @(posedge clk_link);
    load_select_n <= (op == 0);
    rw_select <= (op == 2);
    addr <= (op == 0) ? ~addr : a;
    // second word for the coming k-bar rise, else a changing idle pattern
    if (w2v_q) begin
      dq_in <= w2_q.data;
      byte_write_select_n <= ~w2_q.be;
    end else begin
      dq_in <= ~dq_in;
      byte_write_select_n <= ~byte_write_select_n;
    end
    #20;
    hi_s = {dq_oe, dq_out};
    @(negedge clk_link);
    // first word of last cycle's write, for the next k rise
    if (pv_q) begin
      dq_in <= p1_q.data;
      byte_write_select_n <= ~p1_q.be;
    end else begin
      dq_in <= ~dq_in;
      byte_write_select_n <= ~byte_write_select_n;
    end
    w2_q = p2_q;
    w2v_q = pv_q;
    p1_q.data = d1;
    p1_q.be = ~s1;
    p2_q.data = d2;
    p2_q.be = ~s2;
    pv_q = (op == 1);
    #20;
    lo_s = {dq_oe, dq_out};
  endtask
endmodule
`default_nettype wire

/* dv/test_ddr_burst2_sram_write_path.sv */
// self-checking bench of the burst sram with a controller model on the link
`timescale 1ns/1ps
`default_nettype none
module test_ddr_burst2_sram_write_path;
  import ddrsw_pkg::*;
  localparam int AW = 6; // small address space
  // clocks, reset, straps and pins
  logic clk_sys, clk_link, link_run, reset_n, out_clk_p, out_clk_n, dll_off_n;
  logic load_select_n, rw_select, dq_oe, echo_clock, echo_clock_n;
  logic single_clock_mode, dll_locked, impedance_update;
  logic [AW-1:0] addr;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic [NBYTES-1:0] byte_write_select_n;
  logic [DATA_W:0] hi_s, lo_s;
  logic [DATA_W-1:0] exp_mem [0:63]; // expected array contents
  int errors, tests_run;
  ddrsw_top #(.ADDR_W(AW), .LOCK_CYC(8), .IMP_CYC(8), .STOP_NS(200)) ddrsw_top_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_link(clk_link), .load_select_n(load_select_n),
    .rw_select(rw_select), .addr(addr), .dq_in(dq_in), .byte_write_select_n(byte_write_select_n),
    .dq_out(dq_out), .dq_oe(dq_oe), .out_clk_p(out_clk_p), .out_clk_n(out_clk_n),
    .dll_off_n(dll_off_n), .echo_clock(echo_clock), .echo_clock_n(echo_clock_n),
    .single_clock_mode(single_clock_mode), .dll_locked(dll_locked),
    .impedance_update(impedance_update));
  ddrsw_ctrl_model #(.ADDR_W(AW)) ddrsw_ctrl_model_i (
    .clk_link(clk_link), .dq_out(dq_out), .dq_oe(dq_oe), .load_select_n(load_select_n),
    .rw_select(rw_select), .addr(addr), .dq_in(dq_in), .byte_write_select_n(byte_write_select_n),
    .hi_s(hi_s), .lo_s(lo_s));
  // system clock, 5 ns
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // link clock, 125 ns, offset in phase; stands still while link_run is low
  initial begin
    clk_link = 1'b0;
    #7;
    forever #62.5 if (link_run) clk_link = ~clk_link;
  end
  task automatic final_report();
    $display("errors %0d, comparisons %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_data(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: data %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  // byte-lane merge of a written word over the old contents
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
                                              input logic [DATA_W-1:0] n,
                                              input logic [NBYTES-1:0] s);
    logic [DATA_W-1:0] r;
    r = o;
    if (!s[0]) r[BYTE_W-1:0] = n[BYTE_W-1:0];
    if (!s[1]) r[DATA_W-1:BYTE_W] = n[DATA_W-1:BYTE_W];
    return r;
  endfunction
  task automatic nop();
    ddrsw_ctrl_model_i.cycle(0, '0, '0, 2'h3, '0, 2'h3);
  endtask
  // write burst; second word lands at the address with lsb inverted
  task automatic wr(input logic [AW-1:0] a, input logic [DATA_W-1:0] d1,
                    input logic [NBYTES-1:0] s1, input logic [DATA_W-1:0] d2,
                    input logic [NBYTES-1:0] s2);
    ddrsw_ctrl_model_i.cycle(1, a, d1, s1, d2, s2);
    exp_mem[a] = merge(exp_mem[a], d1, s1);
    exp_mem[{a[AW-1:1], ~a[0]}] = merge(exp_mem[{a[AW-1:1], ~a[0]}], d2, s2);
  endtask
  // read burst and check both words and the release of the pins
  task automatic rd_chk(input logic [AW-1:0] a);
    ddrsw_ctrl_model_i.cycle(2, a, '0, 2'h3, '0, 2'h3);
    nop();
    nop();
    chk_data(lo_s, {1'b1, exp_mem[a]});
    nop();
    chk_data(hi_s, {1'b1, exp_mem[{a[AW-1:1], ~a[0]}]});
    chk_flag(lo_s[DATA_W], 1'b0);
  endtask
  task automatic wait_lock(input logic exp);
    for (int i = 0; i < 40 && dll_locked !== exp; i++) @(posedge clk_link);
    chk_flag(dll_locked, exp);
    if (dll_locked !== exp) final_report();
  endtask
  task automatic t_reset();
    chk_flag(dq_oe, 1'b0);
    chk_flag(echo_clock, 1'b0);
    chk_flag(dll_locked, 1'b0);
  endtask
  // back-to-back writes with both lsb values and every byte select pattern
  task automatic t_burst();
    wr(6'h08, 18'h12345, 2'h0, 18'h2abcd, 2'h0);
    chk_flag(single_clock_mode, 1'b1);
    wr(6'h05, 18'h00111, 2'h0, 18'h3f00f, 2'h0);
    wr(6'h09, 18'h1ffff, 2'h2, 18'h0aaaa, 2'h3);
    wr(6'h04, 18'h15555, 2'h1, 18'h02222, 2'h2);
    nop();
    nop();
    rd_chk(6'h08);
    rd_chk(6'h05);
  endtask
  // read right after a partial write sees the posted data merged
  task automatic t_posted();
    wr(6'h0c, 18'h3c3c3, 2'h0, 18'h05a5a, 2'h0);
    nop();
    wr(6'h0c, 18'h11111, 2'h2, 18'h2eeee, 2'h1);
    rd_chk(6'h0c);
    rd_chk(6'h0d);
  endtask
  // lock, disable pin and clock stop
  task automatic t_dll();
    wait_lock(1'b1);
    @(posedge clk_link);
    dll_off_n <= 1'b0;
    wait_lock(1'b0);
    repeat (4) @(posedge clk_link);
    dll_off_n <= 1'b1;
    wait_lock(1'b1);
    @(posedge clk_link);
    link_run = 1'b0;
    #300;
    link_run = 1'b1;
    repeat (5) @(posedge clk_link);
    #1;
    chk_flag(dll_locked, 1'b0);
    wait_lock(1'b1);
  endtask
  initial begin
    reset_n = 1'b0;
    link_run = 1'b1;
    out_clk_p = 1'b1;
    out_clk_n = 1'b1;
    dll_off_n = 1'b1;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_link);
    t_reset();
    @(posedge clk_link);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_link);
    t_burst();
    t_posted();
    t_dll();
    final_report();
  end
endmodule
`default_nettype wire
